// ---- verilog/tacap_pkg.sv ----
// Purpose: Constants shared by the auto-reload and capture timer.
// Assumes: APB slave, 32-bit data, one register per aligned word, pclk at 100 MHz.
// Notes:   Rule summary follows.
`default_nettype none

package tacap_pkg;
   // Register indexes; a register's byte address is four times its index.
   localparam logic [11:0] TACAP_CTRL_IDX     = 12'h091;
   localparam logic [11:0] TACAP_RLL_IDX      = 12'h092;
   localparam logic [11:0] TACAP_RLH_IDX      = 12'h093;
   localparam logic [11:0] TACAP_CNTL_IDX     = 12'h094;
   localparam logic [11:0] TACAP_CNTH_IDX     = 12'h095;
   localparam logic [11:0] TACAP_CLKSEL_IDX   = 12'h098;
   localparam logic [11:0] TACAP_IRQ_STAT_IDX = 12'h0a0;
   localparam logic [11:0] TACAP_IRQ_EN_IDX   = 12'h0a4;
   localparam logic [11:0] TACAP_IRQ_CLR_IDX  = 12'h0a8;
   // Register byte addresses, one aligned word each.
   localparam logic [11:0] TACAP_CTRL_OFF     = {TACAP_CTRL_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_RLL_OFF      = {TACAP_RLL_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_RLH_OFF      = {TACAP_RLH_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_CNTL_OFF     = {TACAP_CNTL_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_CNTH_OFF     = {TACAP_CNTH_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_CLKSEL_OFF   = {TACAP_CLKSEL_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_IRQ_STAT_OFF = {TACAP_IRQ_STAT_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_IRQ_EN_OFF   = {TACAP_IRQ_EN_IDX[9:0], 2'b00};
   localparam logic [11:0] TACAP_IRQ_CLR_OFF  = {TACAP_IRQ_CLR_IDX[9:0], 2'b00};
   // Control register fields.
   localparam int TACAP_B_HOVF   = 7;
   localparam int TACAP_B_LOVF   = 6;
   localparam int TACAP_B_LIRQEN = 5;
   localparam int TACAP_B_CAPEN  = 4;
   localparam int TACAP_B_SPLIT  = 3;
   localparam int TACAP_B_RUN    = 2;
   localparam int TACAP_B_CAPSEL = 1;
   localparam int TACAP_B_EXTSEL = 0;
   // Clock select register fields.
   localparam int TACAP_B_HCLK   = 1;
   localparam int TACAP_B_LCLK   = 0;
   // Interrupt status fields.
   localparam int TACAP_B_IRQ_H  = 0;
   localparam int TACAP_B_IRQ_L  = 1;
   // Reset values.
   localparam logic [7:0] TACAP_CTRL_RST = 8'h00;
   localparam logic [7:0] TACAP_BYTE_RST = 8'h00;
   // Prescale and divide counts.
   localparam int         TACAP_SYS_DIV    = 12;
   localparam logic [3:0] TACAP_SYS_DIV_M1 = 4'(TACAP_SYS_DIV - 1);
   localparam int         TACAP_SLOW_DIV   = 8;
   localparam logic [2:0] TACAP_SLOW_DIV_M1 = 3'(TACAP_SLOW_DIV - 1);
endpackage

`default_nettype wire

// ---- verilog/tacap_sync.sv ----
// Purpose: Three-stage synchroniser with one-cycle rising-edge pulse.
// Assumes: Input is asynchronous to pclk.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module tacap_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      rise_pulse
);
   import tacap_pkg::*;

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   // Shift chain; a change counts once stages two and three agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Agreed level; it follows the pin only while stages two and three match.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         lvl_q <= s3_q;
      end
   end

   // Rising edge seen in pclk domain, one cycle wide.
   assign rise_pulse = (s2_q == s3_q) & s3_q & ~lvl_q;
endmodule

`default_nettype wire

// ---- verilog/tacap_div8.sv ----
// Purpose: Divide a synchronised slow clock edge stream by eight.
// Assumes: edge_in is a one-cycle pulse per slow clock cycle.
// Notes:   Emits one-cycle pulse every eighth input pulse.
`default_nettype none

module tacap_div8 (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic edge_in,
   output logic      tick
);
   import tacap_pkg::*;

   logic [2:0] cnt_q;

   // Count edges; wrap after the eighth.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 3'h0;
      end else if (edge_in) begin
         cnt_q <= (cnt_q == TACAP_SLOW_DIV_M1) ? 3'h0 : cnt_q + 3'h1;
      end
   end

   assign tick = edge_in && (cnt_q == TACAP_SLOW_DIV_M1);
endmodule

`default_nettype wire

// ---- verilog/tacap_timer.sv ----
// Purpose: 16-bit / dual 8-bit auto-reload timer with oscillator capture, APB slave.
// Assumes: ext_osc and rtc_osc are asynchronous slow clocks sampled as data.
// Notes:   One level interrupt; status bits are sticky and cleared by write.
//
// Decided for this implementation: register access over APB.
`default_nettype none

module tacap_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_osc,
   input  wire logic        rtc_osc,
   output logic             irq
);
   import tacap_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers and internal signals.

   logic [7:0]  ctrl_q;
   logic [7:0]  rll_q;
   logic [7:0]  rlh_q;
   logic [7:0]  cntl_q;
   logic [7:0]  cnth_q;
   logic [1:0]  clksel_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_en_q;
   logic [3:0]  pre12_q;
   logic [31:0] prdata_q;
   logic        tick12;
   logic        ext_edge;
   logic        rtc_edge;
   logic        ext_tick;
   logic        rtc_tick;
   logic        cap_tick;
   logic        l_tick;
   logic        h_tick;
   logic        split;
   logic        capen;
   logic        l_en;
   logic        h_en;
   logic        l_wrap;
   logic        l_reload;
   logic        h_wrap;
   logic        l_ovf;
   logic        h_ovf;
   logic        cap_ev;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        ctrl_wr;
   logic        irq_h_ev;
   logic        irq_l_ev;

   // Selects one source tick for a byte from its clock-select bit and the shared EXTSEL control bit.
   function automatic logic pick_tick(input logic fast, input logic ext_sel,
                                      input logic t12, input logic tx);
      pick_tick = fast ? 1'b1 : (ext_sel ? tx : t12);
   endfunction

   // Tells whether an address is one of the implemented registers.
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == TACAP_CTRL_OFF) || (a == TACAP_RLL_OFF) || (a == TACAP_RLH_OFF) ||
                  (a == TACAP_CNTL_OFF) || (a == TACAP_CNTH_OFF) || (a == TACAP_CLKSEL_OFF) ||
                  (a == TACAP_IRQ_STAT_OFF) || (a == TACAP_IRQ_EN_OFF) ||
                  (a == TACAP_IRQ_CLR_OFF);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Clock sources.

   // Slow oscillators pass three flops and yield one pulse per rising edge.
   tacap_sync u_sync_ext (
      .pclk       (pclk),
      .presetn    (presetn),
      .async_in   (ext_osc),
      .rise_pulse (ext_edge)
   );

   tacap_sync u_sync_rtc (
      .pclk       (pclk),
      .presetn    (presetn),
      .async_in   (rtc_osc),
      .rise_pulse (rtc_edge)
   );

   // Eight-cycle dividers for counting and capture.
   tacap_div8 u_div_ext (
      .pclk    (pclk),
      .presetn (presetn),
      .edge_in (ext_edge),
      .tick    (ext_tick)
   );

   tacap_div8 u_div_rtc (
      .pclk    (pclk),
      .presetn (presetn),
      .edge_in (rtc_edge),
      .tick    (rtc_tick)
   );

   // System clock divided by twelve.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre12_q <= 4'h0;
      end else begin
         pre12_q <= (pre12_q == TACAP_SYS_DIV_M1) ? 4'h0 : pre12_q + 4'h1;
      end
   end

   assign tick12 = (pre12_q == TACAP_SYS_DIV_M1);

   ////////////////////////////////////////////////////////////////////////
   // Counting control.

   // Mode decode and per-byte clock enables.
   assign split = ctrl_q[TACAP_B_SPLIT];
   assign capen = ctrl_q[TACAP_B_CAPEN];
   assign l_tick = pick_tick(clksel_q[TACAP_B_LCLK], ctrl_q[TACAP_B_EXTSEL], tick12, ext_tick);
   assign h_tick = pick_tick(clksel_q[TACAP_B_HCLK], ctrl_q[TACAP_B_EXTSEL], tick12, ext_tick);
   // Low byte free-runs in split mode; the run bit gates the rest.
   assign l_en   = l_tick & (split | ctrl_q[TACAP_B_RUN]);
   assign h_en   = split ? (h_tick & ctrl_q[TACAP_B_RUN]) : (l_en & (cntl_q == 8'hff));
   assign l_wrap = l_en & (cntl_q == 8'hff);
   assign h_wrap = h_en & (cnth_q == 8'hff);
   assign l_ovf  = l_wrap;
   assign h_ovf  = h_wrap;
   // In 16-bit mode the low byte reloads only on a full wrap, otherwise it rolls to zero.
   assign l_reload = split ? l_wrap : h_wrap;

   // Capture source: eighth cycle of external or real-time oscillator.
   assign cap_tick = ctrl_q[TACAP_B_CAPSEL] ? ext_tick : rtc_tick;
   assign cap_ev   = capen & cap_tick;

   ////////////////////////////////////////////////////////////////////////
   // APB decode.

   assign wr      = psel & penable & pwrite;
   assign rd      = psel & ~pwrite & ~penable;
   assign mapped  = is_mapped(paddr);
   assign ctrl_wr = wr & (paddr == TACAP_CTRL_OFF);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Counter low byte: reload on wrap, software write otherwise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cntl_q <= TACAP_BYTE_RST;
      end else if (l_reload) begin
         cntl_q <= rll_q;
      end else if (wr && paddr == TACAP_CNTL_OFF) begin
         cntl_q <= pwdata[7:0];
      end else if (l_en) begin
         cntl_q <= cntl_q + 8'h01;
      end
   end

   // Counter high byte: in 16-bit mode it advances on low-byte carry.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnth_q <= TACAP_BYTE_RST;
      end else if (h_wrap) begin
         cnth_q <= rlh_q;
      end else if (wr && paddr == TACAP_CNTH_OFF) begin
         cnth_q <= pwdata[7:0];
      end else if (h_en) begin
         cnth_q <= cnth_q + 8'h01;
      end
   end

   // Reload bytes: capture copies the live counter, which wins over a write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rll_q <= TACAP_BYTE_RST;
         rlh_q <= TACAP_BYTE_RST;
      end else if (cap_ev) begin
         rll_q <= cntl_q;
         rlh_q <= cnth_q;
      end else begin
         if (wr && paddr == TACAP_RLL_OFF) begin
            rll_q <= pwdata[7:0];
         end
         if (wr && paddr == TACAP_RLH_OFF) begin
            rlh_q <= pwdata[7:0];
         end
      end
   end

   // Control: software writes all bits; hardware only sets flags, and a set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= TACAP_CTRL_RST;
      end else begin
         if (ctrl_wr) begin
            ctrl_q <= pwdata[7:0];
         end
         if (h_ovf || cap_ev) begin
            ctrl_q[TACAP_B_HOVF] <= 1'b1;
         end
         if (l_ovf) begin
            ctrl_q[TACAP_B_LOVF] <= 1'b1;
         end
      end
   end

   // Clock select bits for both bytes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clksel_q <= 2'h0;
      end else if (wr && paddr == TACAP_CLKSEL_OFF) begin
         clksel_q <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts.

   // High event covers overflow and capture; low event needs its own enable.
   assign irq_h_ev = h_ovf | cap_ev;
   assign irq_l_ev = l_ovf & ctrl_q[TACAP_B_LIRQEN];

   // Sticky status; set beats a same-cycle clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q <= ((wr && paddr == TACAP_IRQ_CLR_OFF) ? (irq_stat_q & ~pwdata[1:0]) : irq_stat_q)
                       | {irq_l_ev, irq_h_ev};
      end
   end

   // Interrupt enable register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_q <= 2'h0;
      end else if (wr && paddr == TACAP_IRQ_EN_OFF) begin
         irq_en_q <= pwdata[1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   ////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup cycle.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd) begin
         unique case (paddr)
            TACAP_CTRL_OFF:     prdata_q <= {24'h0, ctrl_q};
            TACAP_RLL_OFF:      prdata_q <= {24'h0, rll_q};
            TACAP_RLH_OFF:      prdata_q <= {24'h0, rlh_q};
            TACAP_CNTL_OFF:     prdata_q <= {24'h0, cntl_q};
            TACAP_CNTH_OFF:     prdata_q <= {24'h0, cnth_q};
            TACAP_CLKSEL_OFF:   prdata_q <= {30'h0, clksel_q};
            TACAP_IRQ_STAT_OFF: prdata_q <= {30'h0, irq_stat_q};
            TACAP_IRQ_EN_OFF:   prdata_q <= {30'h0, irq_en_q};
            default:            prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   // A 16-bit wrap reloads both bytes on the next cycle.
   reload16_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!split && h_wrap && !cap_ev && !wr) |=> (cntl_q == $past(rll_q)) && (cnth_q == $past(rlh_q)))
      else $error("16-bit wrap did not reload");

   // High overflow sets its flag.
   hflag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      h_ovf |=> ctrl_q[TACAP_B_HOVF])
      else $error("High overflow flag not set");

   // Low overflow sets its flag.
   lflag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      l_ovf |=> ctrl_q[TACAP_B_LOVF])
      else $error("Low overflow flag not set");

   // Flags fall only through a control write.
   flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($fell(ctrl_q[TACAP_B_HOVF]) || $fell(ctrl_q[TACAP_B_LOVF])) |-> $past(ctrl_wr))
      else $error("Flag cleared without software write");

   // Capture copies the counter into the reload pair.
   capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_ev |=> (rlh_q == $past(cnth_q)) && (rll_q == $past(cntl_q)) && ctrl_q[TACAP_B_HOVF])
      else $error("Capture did not copy counter");

   // Split low byte counts even with run bit clear.
   split_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      (split && !ctrl_q[TACAP_B_RUN] && l_tick && cntl_q != 8'hff && !wr) |=> cntl_q == $past(cntl_q) + 8'h01)
      else $error("Split low byte did not count");

   // Split high byte holds while run bit clear.
   split_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      (split && !ctrl_q[TACAP_B_RUN] && !wr) |=> $stable(cnth_q))
      else $error("Split high byte moved while stopped");

   // Low interrupt status needs its enable bit.
   low_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(irq_stat_q[TACAP_B_IRQ_L]) |-> $past(ctrl_q[TACAP_B_LIRQEN]) && $past(l_ovf))
      else $error("Low interrupt without enable");

   // Divide by twelve spacing.
   div12_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
      else $error("Divide by twelve spacing wrong");

   // In 16-bit mode a low-byte wrap alone carries into the high byte.
   low_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!split && l_wrap && !h_wrap && !wr) |=> (cntl_q == 8'h00) && (cnth_q == $past(cnth_q) + 8'h01))
      else $error("16-bit low wrap did not carry");

   // Split low byte reloads from its own reload byte.
   split_low_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (split && l_wrap) |=> cntl_q == $past(rll_q))
      else $error("Split low byte did not reload");

   // Split high byte reloads from its own reload byte.
   split_high_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (split && h_wrap) |=> cnth_q == $past(rlh_q))
      else $error("Split high byte did not reload");

   // High overflow or capture always reaches the sticky status.
   high_status_a: assert property (@(posedge pclk) disable iff (!presetn)
      (h_ovf || cap_ev) |=> irq_stat_q[TACAP_B_IRQ_H])
      else $error("High event missed in status");

   // Each capture is a single pclk pulse.
   capture_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_ev |=> !cap_ev)
      else $error("Capture pulse longer than one cycle");
endmodule

`default_nettype wire

// ---- verification/tb_tacap_timer.sv ----
// Purpose: Self-checking bench for the auto-reload and capture timer.
// Assumes: Zero-wait APB slave; the bench drives both slow oscillators itself.
// Notes:   Table rows cover register access; hand tests cover counting, flags and capture.
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb_tacap_timer import tacap_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} tacap_row_t;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        ext_osc, rtc_osc, osc_on, osc_sel, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] cap_a, cap_b;
   int          n_mismatch, checked, n_edges;

   // Ordinary register rows: address, data written, value read back, error expected.
   tacap_row_t rows [8] = '{'{TACAP_CTRL_OFF, 32'h08, 32'h08, 1'b0}, '{TACAP_RLL_OFF, 32'ha5, 32'ha5, 1'b0},
      '{TACAP_RLH_OFF, 32'h3c, 32'h3c, 1'b0}, '{TACAP_CLKSEL_OFF, 32'h03, 32'h03, 1'b0},
      '{TACAP_IRQ_EN_OFF, 32'h03, 32'h03, 1'b0}, '{TACAP_IRQ_STAT_OFF, 32'h03, 32'h00, 1'b0},
      '{12'h0fc, 32'hff, 32'h00, 1'b1}, '{TACAP_CTRL_OFF, 32'h00, 32'h00, 1'b0}};
   logic [11:0] rst_addr [8] = '{TACAP_CTRL_OFF, TACAP_RLL_OFF, TACAP_RLH_OFF, TACAP_CNTL_OFF,
      TACAP_CNTH_OFF, TACAP_CLKSEL_OFF, TACAP_IRQ_EN_OFF, TACAP_IRQ_STAT_OFF};

   tacap_timer i_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .ext_osc (ext_osc),
      .rtc_osc (rtc_osc),
      .irq     (irq)
   );

   // Clock of 100 MHz.
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // Slow oscillator of 20 pclk periods, running only while enabled.
   always begin
      @(posedge pclk);
      if (osc_on) begin
         repeat (9) @(posedge pclk);
         if (osc_sel) ext_osc <= 1'b1;
         else rtc_osc <= 1'b1;
         n_edges++;
         repeat (10) @(posedge pclk);
         ext_osc <= 1'b0;
         rtc_osc <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) n_mismatch++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(a, 1'b0, 32'h0);
   endtask

   // Waits until n oscillator edges have passed, plus the synchroniser delay.
   task automatic edges(input int n);
      while (n_edges < n) @(posedge pclk);
      repeat (6) @(posedge pclk);
   endtask

   task automatic osc_stop;
      osc_on <= 1'b0;
      repeat (14) @(posedge pclk);
      n_edges = 0;
   endtask

   task automatic wait_irq;
      repeat (40) if (irq !== 1'b1) @(posedge pclk);
   endtask

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run length.
   initial begin
      repeat (30000) @(posedge pclk);
      n_mismatch++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {psel, penable, pwrite, ext_osc, rtc_osc, osc_on, osc_sel} = '0;
      paddr = '0;
      pwdata = '0;
      presetn = 1'b0;
      n_mismatch = 0;
      checked = 0;
      n_edges = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].w);
         `CHK("write error", rows[k].e, rerr);
         rd(rows[k].a);
         `CHK("readback", rows[k].r, rdat);
      end
      $display("test register table done");
      do_reset();
      foreach (rst_addr[k]) begin
         rd(rst_addr[k]);
         `CHK("reset value", 32'h0, rdat);
      end
      `CHK("irq after reset", 1'b0, irq);
      $display("test reset done");
      // Capture on real-time (s=0) then external (s=1) oscillator.
      for (int s = 0; s < 2; s++) begin
         wr(TACAP_CLKSEL_OFF, 32'h1);
         wr(TACAP_CNTL_OFF, 32'h0);
         wr(TACAP_CNTH_OFF, 32'h0);
         wr(TACAP_CTRL_OFF, 32'h14 | 32'(s * 2));
         osc_sel <= s[0];
         osc_on <= 1'b1;
         edges(8);
         rd(TACAP_CTRL_OFF);
         `CHK("capture flag", 32'h94 | 32'(s * 2), rdat);
         rd(TACAP_RLL_OFF);
         cap_a[7:0] = rdat[7:0];
         rd(TACAP_RLH_OFF);
         cap_a[15:8] = rdat[7:0];
         wr(TACAP_CTRL_OFF, 32'h14 | 32'(s * 2));
         edges(15);
         rd(TACAP_CTRL_OFF);
         `CHK("no early capture", 32'h54 | 32'(s * 2), rdat);
         edges(16);
         rd(TACAP_RLL_OFF);
         cap_b[7:0] = rdat[7:0];
         rd(TACAP_RLH_OFF);
         cap_b[15:8] = rdat[7:0];
         `CHK("capture span", 16'd160, cap_b - cap_a);
         wr(TACAP_CTRL_OFF, 32'h0);
         osc_stop();
      end
      $display("test capture done");
      // Counting on external oscillator divided by eight.
      wr(TACAP_CLKSEL_OFF, 32'h0);
      wr(TACAP_CNTL_OFF, 32'h0);
      wr(TACAP_CTRL_OFF, 32'h05);
      osc_sel <= 1'b1;
      osc_on <= 1'b1;
      edges(16);
      wr(TACAP_CTRL_OFF, 32'h01);
      osc_stop();
      rd(TACAP_CNTL_OFF);
      `CHK("ext div8 count", 32'h2, rdat);
      // Counting on pclk divided by twelve.
      wr(TACAP_CNTL_OFF, 32'h0);
      wr(TACAP_CTRL_OFF, 32'h04);
      repeat (120) @(posedge pclk);
      wr(TACAP_CTRL_OFF, 32'h0);
      rd(TACAP_CNTL_OFF);
      `CHK("div12 count", 1'b1, rdat >= 32'd9 && rdat <= 32'd11);
      $display("test clock sources done");
      // Sixteen-bit wrap: reload, high flag, sticky interrupt.
      wr(TACAP_IRQ_CLR_OFF, 32'h3);
      wr(TACAP_IRQ_EN_OFF, 32'h1);
      wr(TACAP_RLL_OFF, 32'hf0);
      wr(TACAP_RLH_OFF, 32'hff);
      wr(TACAP_CNTL_OFF, 32'hfa);
      wr(TACAP_CNTH_OFF, 32'hff);
      wr(TACAP_CLKSEL_OFF, 32'h1);
      wr(TACAP_CTRL_OFF, 32'h04);
      wait_irq();
      `CHK("overflow irq", 1'b1, irq);
      rd(TACAP_CTRL_OFF);
      `CHK("both flags", 32'hc4, rdat);
      wr(TACAP_CTRL_OFF, 32'h80);
      rd(TACAP_CNTH_OFF);
      `CHK("reloaded high", 32'hff, rdat);
      rd(TACAP_CNTL_OFF);
      `CHK("reloaded low", 1'b1, rdat >= 32'hf0);
      repeat (50) @(posedge pclk);
      rd(TACAP_CTRL_OFF);
      `CHK("flag sticky", 32'h80, rdat);
      `CHK("irq sticky", 1'b1, irq);
      wr(TACAP_IRQ_CLR_OFF, 32'h3);
      wr(TACAP_CTRL_OFF, 32'h0);
      `CHK("irq cleared", 1'b0, irq);
      // Low-byte wrap in sixteen-bit mode with low interrupt enabled.
      wr(TACAP_IRQ_EN_OFF, 32'h2);
      wr(TACAP_CNTH_OFF, 32'h0);
      wr(TACAP_CNTL_OFF, 32'hfc);
      wr(TACAP_CTRL_OFF, 32'h24);
      wait_irq();
      `CHK("low wrap irq", 1'b1, irq);
      wr(TACAP_CTRL_OFF, 32'h60);
      rd(TACAP_IRQ_STAT_OFF);
      `CHK("low only status", 32'h2, rdat);
      rd(TACAP_CTRL_OFF);
      `CHK("low flag", 32'h60, rdat);
      rd(TACAP_CNTH_OFF);
      `CHK("carry to high", 32'h1, rdat);
      wr(TACAP_IRQ_CLR_OFF, 32'h3);
      wr(TACAP_CTRL_OFF, 32'h0);
      $display("test sixteen bit done");
      // Split mode: low byte runs alone, high byte gated by run bit.
      wr(TACAP_IRQ_EN_OFF, 32'h3);
      wr(TACAP_RLL_OFF, 32'hf0);
      wr(TACAP_RLH_OFF, 32'h80);
      wr(TACAP_CNTL_OFF, 32'hfc);
      wr(TACAP_CNTH_OFF, 32'hfe);
      wr(TACAP_CLKSEL_OFF, 32'h3);
      wr(TACAP_CTRL_OFF, 32'h08);
      repeat (30) @(posedge pclk);
      rd(TACAP_CNTH_OFF);
      `CHK("high stopped", 32'hfe, rdat);
      rd(TACAP_CTRL_OFF);
      `CHK("split low flag", 32'h48, rdat);
      `CHK("no low irq", 1'b0, irq);
      rd(TACAP_CNTL_OFF);
      `CHK("low reload", 1'b1, rdat >= 32'hf0);
      wr(TACAP_CTRL_OFF, 32'h4c);
      wait_irq();
      `CHK("high irq", 1'b1, irq);
      wr(TACAP_CTRL_OFF, 32'hc0);
      rd(TACAP_CNTH_OFF);
      `CHK("high reload", 1'b1, rdat >= 32'h80 && rdat <= 32'hff);
      wr(TACAP_IRQ_CLR_OFF, 32'h3);
      wr(TACAP_CTRL_OFF, 32'h28);
      wait_irq();
      `CHK("split low irq", 1'b1, irq);
      wr(TACAP_CTRL_OFF, 32'h0);
      rd(TACAP_IRQ_STAT_OFF);
      `CHK("split low status", 32'h2, rdat);
      $display("test split done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
